// file: pkg/rsq_consts.svh
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
`define RSQ_FN_RD_COILS 8'h01
`define RSQ_FN_RD_REGS 8'h03
`define RSQ_FN_WR_COIL 8'h05
`define RSQ_FN_WR_REG 8'h06
`define RSQ_FN_LOOPBACK 8'h08
`define RSQ_FN_WR_COILS 8'h0F
`define RSQ_FN_WR_REGS 8'h10
`define RSQ_EXC_FLAG 8'h80
`define RSQ_EXC_NO_FUNC 8'h01
`define RSQ_EXC_FORMAT 8'h03
`define RSQ_ADDR_BCAST 8'h00
`define RSQ_GRP_A0 8'hFA
`define RSQ_GRP_A1 8'hFB
`define RSQ_GRP_A2 8'hFC
`define RSQ_GRP_A3 8'hFD
`define RSQ_GRP_A4 8'hFE
`define RSQ_GRP_HI0 8'h09
`define RSQ_GRP_HI1 8'h13
`define RSQ_GRP_HI2 8'h1D
`define RSQ_GRP_HI3 8'h27
`define RSQ_GRP_HI4 8'hF7
`define RSQ_STN_MIN 8'h01
`define RSQ_STN_MAX 8'h20
`define RSQ_MAX_COILS 16'h0020
`define RSQ_MAX_REGS 16'h0010
`define RSQ_COIL_ON 16'hFF00
`define RSQ_FIX_LEN 9'h008
`define RSQ_MIN_LEN 9'h004
`define RSQ_MULTI_HDR 9'h009
`define RSQ_BUF_FULL 9'h100
`define RSQ_T35_BITS 5'h18
`define RSQ_CLK_NS 32'h00000014
`define RSQ_MS_NS 32'h000F4240
`define RSQ_WAIT_MAX_MS 11'h3E8
`define RSQ_CRC_INIT 16'hFFFF
`define RSQ_CRC_POLY 16'hA001
`endif

// file: pkg/rsq_pkg.sv
package rsq_pkg;
  typedef enum logic [2:0] {
    sIdle, sCheck, sAsk, sWrite, sWait, sFetch, sLoad, sSend
  } rsq_state_t;
  typedef enum logic [1:0] {kEcho, kRead, kExc} rsq_kind_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } rsq_rx_t;
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] qty;
  } rsq_req_t;
endpackage : rsq_pkg

// file: logic/rsq_crc16.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.svh"
module rsq_crc16 (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic update,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RSQ_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte

  always_ff @(posedge clock) begin
    if (rst || clear) begin
      crc <= `RSQ_CRC_INIT;
    end else if (update) begin
      crc <= crcByte(crc, data);
    end
  end
endmodule : rsq_crc16
`default_nettype wire

// file: logic/rsq_frame_mem.sv
`timescale 1ns/100ps
`default_nettype none
module rsq_frame_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:255];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : rsq_frame_mem
`default_nettype wire

// file: logic/rsq_query_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.svh"
module rsq_query_slave #(
  parameter int CYC_PER_MS = `RSQ_MS_NS / `RSQ_CLK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire rsq_pkg::rsq_rx_t rxIn,
  input wire logic [7:0] station,
  input wire logic [15:0] bitCycles,
  input wire logic [10:0] replyExtraWaitTime,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output var rsq_pkg::rsq_req_t appReq,
  output logic appReqValid,
  output logic appBcast,
  input wire logic appAck,
  input wire logic [7:0] appExc,
  output logic [7:0] appRdIdx,
  input wire logic [7:0] appRdByte,
  output logic appWrValid,
  output logic [7:0] appWrIdx,
  output logic [7:0] appWrByte
);
  rsq_pkg::rsq_state_t state_q, state_d;
  rsq_pkg::rsq_kind_t kind_q, kind_d;
  logic [6:0][7:0] hdr_q;
  logic [8:0] rxLen_q, bodyLen_q, bodyLen_d, txIdx_q;
  logic rxBad_q, busy_q, bcast_q, bcast_d, wrPhase_q;
  logic [20:0] idle_q, t35;
  logic [7:0] excCode_q, excCode_d, rdCnt_q, rdCnt_d, wrIdx_q;
  logic [15:0] msCyc_q, crcVal, qty;
  logic [10:0] msCnt_q, waitMs;
  logic [7:0] func, addr, bc, memRd, memRdAddr, txByte, crcIn, fmtExc;
  logic crcClr, crcUpd, memWr, preTx, busyNow, own, known, lenOk, accept;
  logic idleDone, waitDone;

  function automatic logic isWrite(input logic [7:0] f);
    return f == `RSQ_FN_WR_COIL || f == `RSQ_FN_WR_REG ||
           f == `RSQ_FN_WR_COILS || f == `RSQ_FN_WR_REGS;
  endfunction : isWrite

  function automatic logic inGroup(input logic [7:0] a, input logic [7:0] s);
    logic [7:0] lo, hi;
    lo = 8'hFF;
    hi = 8'h00;
    case (a)
      `RSQ_GRP_A0: begin lo = `RSQ_STN_MIN; hi = `RSQ_GRP_HI0; end
      `RSQ_GRP_A1: begin lo = `RSQ_GRP_HI0 + 8'h01; hi = `RSQ_GRP_HI1; end
      `RSQ_GRP_A2: begin lo = `RSQ_GRP_HI1 + 8'h01; hi = `RSQ_GRP_HI2; end
      `RSQ_GRP_A3: begin lo = `RSQ_GRP_HI2 + 8'h01; hi = `RSQ_GRP_HI3; end
      `RSQ_GRP_A4: begin lo = `RSQ_GRP_HI3 + 8'h01; hi = `RSQ_GRP_HI4; end
      default: begin lo = 8'hFF; hi = 8'h00; end
    endcase
    return s >= lo && s <= hi;
  endfunction : inGroup

  assign addr = hdr_q[0];
  assign func = hdr_q[1];
  assign qty = {hdr_q[4], hdr_q[5]};
  assign bc = hdr_q[6];
  assign t35 = 21'(bitCycles) * 21'(`RSQ_T35_BITS);
  assign idleDone = idle_q >= t35;
  // Out-of-range settings clamp rather than stall the reply
  assign waitMs = (replyExtraWaitTime > `RSQ_WAIT_MAX_MS) ? `RSQ_WAIT_MAX_MS
                  : replyExtraWaitTime;
  assign waitDone = idleDone && msCnt_q >= waitMs;
  assign preTx = state_q inside {rsq_pkg::sCheck, rsq_pkg::sAsk, rsq_pkg::sWrite,
                                 rsq_pkg::sWait};
  assign busyNow = busy_q | (rxIn.valid & preTx);
  assign own = addr == station;
  assign memWr = state_q == rsq_pkg::sIdle && rxIn.valid && rxLen_q != `RSQ_BUF_FULL;
  assign memRdAddr = (state_q == rsq_pkg::sWrite) ? wrIdx_q : txIdx_q[7:0];
  assign appReq = {func, hdr_q[2], hdr_q[3], qty};
  assign appReqValid = state_q == rsq_pkg::sAsk;
  assign appBcast = bcast_q;
  assign appWrValid = state_q == rsq_pkg::sWrite && wrPhase_q;
  assign appWrIdx = wrIdx_q;
  assign appWrByte = memRd;
  assign crcUpd = memWr || (state_q == rsq_pkg::sLoad && txIdx_q < bodyLen_q);
  assign crcIn = (state_q == rsq_pkg::sIdle) ? rxIn.data : txByte;
  // Held clear through the wait so the reply CRC starts fresh
  assign crcClr = state_q == rsq_pkg::sWait ||
                  (state_q != rsq_pkg::sIdle && state_d == rsq_pkg::sIdle);
  assign accept = !rxBad_q && crcVal == 16'h0000 && rxLen_q >= `RSQ_MIN_LEN &&
                  !busyNow && station >= `RSQ_STN_MIN && station <= `RSQ_STN_MAX &&
                  (own || addr == `RSQ_ADDR_BCAST ||
                   (inGroup(addr, station) && isWrite(func)));

  always_comb begin
    known = 1'b1;
    lenOk = 1'b1;
    fmtExc = 8'h00;
    rdCnt_d = 8'h00;
    case (func)
      `RSQ_FN_RD_COILS: begin
        lenOk = rxLen_q == `RSQ_FIX_LEN;
        if (qty == 16'h0000 || qty > `RSQ_MAX_COILS) fmtExc = `RSQ_EXC_FORMAT;
        rdCnt_d = 8'((qty + 16'h0007) >> 3);
      end
      `RSQ_FN_RD_REGS: begin
        lenOk = rxLen_q == `RSQ_FIX_LEN;
        if (qty == 16'h0000 || qty > `RSQ_MAX_REGS) fmtExc = `RSQ_EXC_FORMAT;
        rdCnt_d = 8'(qty << 1);
      end
      `RSQ_FN_WR_COIL: begin
        lenOk = rxLen_q == `RSQ_FIX_LEN;
        if (qty != `RSQ_COIL_ON && qty != 16'h0000) fmtExc = `RSQ_EXC_FORMAT;
      end
      `RSQ_FN_WR_REG: lenOk = rxLen_q == `RSQ_FIX_LEN;
      `RSQ_FN_LOOPBACK: lenOk = 1'b1;
      `RSQ_FN_WR_COILS: begin
        lenOk = rxLen_q == `RSQ_MULTI_HDR + 9'(bc);
        if (qty == 16'h0000 || qty > `RSQ_MAX_COILS ||
            16'(bc) != ((qty + 16'h0007) >> 3)) fmtExc = `RSQ_EXC_FORMAT;
      end
      `RSQ_FN_WR_REGS: begin
        lenOk = rxLen_q == `RSQ_MULTI_HDR + 9'(bc);
        if (qty == 16'h0000 || qty > `RSQ_MAX_REGS ||
            16'(bc) != (qty << 1)) fmtExc = `RSQ_EXC_FORMAT;
      end
      default: known = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    bcast_d = bcast_q;
    excCode_d = excCode_q;
    bodyLen_d = bodyLen_q;
    case (state_q)
      rsq_pkg::sIdle: begin
        if (rxLen_q != 9'h000 && idleDone && !rxIn.valid) state_d = rsq_pkg::sCheck;
      end
      rsq_pkg::sCheck: begin
        bcast_d = !own;
        if (!accept || !lenOk) begin
          state_d = rsq_pkg::sIdle;
        end else if (!own && !isWrite(func)) begin
          state_d = rsq_pkg::sIdle;
        end else if (!known || fmtExc != 8'h00) begin
          kind_d = rsq_pkg::kExc;
          excCode_d = known ? fmtExc : `RSQ_EXC_NO_FUNC;
          bodyLen_d = 9'h003;
          state_d = own ? rsq_pkg::sWait : rsq_pkg::sIdle;
        end else if (func == `RSQ_FN_LOOPBACK) begin
          kind_d = rsq_pkg::kEcho;
          bodyLen_d = rxLen_q - 9'h002;
          state_d = rsq_pkg::sWait;
        end else begin
          state_d = rsq_pkg::sAsk;
        end
      end
      rsq_pkg::sAsk: begin
        if (appAck && appExc != 8'h00) begin
          kind_d = rsq_pkg::kExc;
          excCode_d = appExc;
          bodyLen_d = 9'h003;
          state_d = bcast_q ? rsq_pkg::sIdle : rsq_pkg::sWait;
        end else if (appAck && isWrite(func)) begin
          kind_d = rsq_pkg::kEcho;
          bodyLen_d = rxLen_q - 9'h002;
          state_d = rsq_pkg::sWrite;
        end else if (appAck) begin
          kind_d = rsq_pkg::kRead;
          bodyLen_d = 9'h003 + 9'(rdCnt_q);
          state_d = rsq_pkg::sWait;
        end
      end
      rsq_pkg::sWrite: begin
        if (wrPhase_q && 9'(wrIdx_q) == rxLen_q - 9'h003) begin
          state_d = bcast_q ? rsq_pkg::sIdle : rsq_pkg::sWait;
        end
      end
      rsq_pkg::sWait: begin
        if (busyNow) state_d = rsq_pkg::sIdle;
        else if (waitDone) state_d = rsq_pkg::sFetch;
      end
      rsq_pkg::sFetch: state_d = rsq_pkg::sLoad;
      rsq_pkg::sLoad: state_d = rsq_pkg::sSend;
      rsq_pkg::sSend: begin
        if (txReady) begin
          state_d = (txIdx_q == bodyLen_q + 9'h001) ? rsq_pkg::sIdle : rsq_pkg::sFetch;
        end
      end
      default: state_d = rsq_pkg::sIdle;
    endcase
  end

  always_comb begin
    txByte = memRd;
    if (txIdx_q == bodyLen_q) begin
      txByte = crcVal[7:0];
    end else if (txIdx_q > bodyLen_q) begin
      txByte = crcVal[15:8];
    end else if (kind_q != rsq_pkg::kEcho) begin
      case (txIdx_q)
        9'h000: txByte = addr;
        9'h001: txByte = (kind_q == rsq_pkg::kExc) ? (func | `RSQ_EXC_FLAG) : func;
        9'h002: txByte = (kind_q == rsq_pkg::kExc) ? excCode_q : rdCnt_q;
        default: txByte = appRdByte;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= rsq_pkg::sIdle;
      kind_q <= rsq_pkg::kEcho;
      bcast_q <= 1'b0;
      excCode_q <= 8'h00;
      bodyLen_q <= 9'h000;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      bcast_q <= bcast_d;
      excCode_q <= excCode_d;
      bodyLen_q <= bodyLen_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) rdCnt_q <= 8'h00;
    else if (state_q == rsq_pkg::sCheck) rdCnt_q <= rdCnt_d;
  end

  // A byte that breaks the silence starts a frame already marked bad
  always_ff @(posedge clock) begin
    if (rst) begin
      rxLen_q <= 9'h000;
      rxBad_q <= 1'b0;
    end else if (state_q == rsq_pkg::sIdle) begin
      if (memWr) rxLen_q <= rxLen_q + 9'h001;
      if (rxIn.valid && (rxIn.err || !memWr)) rxBad_q <= 1'b1;
    end else if (state_d == rsq_pkg::sIdle) begin
      rxLen_q <= {8'h00, busyNow};
      rxBad_q <= busyNow;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !preTx) busy_q <= 1'b0;
    else if (rxIn.valid) busy_q <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hdr_q <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (memWr && rxLen_q == 9'(i)) hdr_q[i] <= rxIn.data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || rxIn.valid) idle_q <= 21'h000000;
    else if (!idleDone) idle_q <= idle_q + 21'h000001;
  end

  always_ff @(posedge clock) begin
    if (rst || state_q != rsq_pkg::sWait) begin
      msCyc_q <= 16'h0000;
      msCnt_q <= 11'h000;
    end else if (msCnt_q < waitMs) begin
      if (msCyc_q == 16'(CYC_PER_MS - 1)) begin
        msCyc_q <= 16'h0000;
        msCnt_q <= msCnt_q + 11'h001;
      end else begin
        msCyc_q <= msCyc_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state_q != rsq_pkg::sWrite) begin
      wrIdx_q <= 8'h02;
      wrPhase_q <= 1'b0;
    end else begin
      wrPhase_q <= !wrPhase_q;
      if (wrPhase_q) wrIdx_q <= wrIdx_q + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txIdx_q <= 9'h000;
      appRdIdx <= 8'h00;
      txValid <= 1'b0;
      txData <= 8'h00;
    end else if (state_q == rsq_pkg::sWait) begin
      txIdx_q <= 9'h000;
      appRdIdx <= 8'hFD;
    end else if (state_q == rsq_pkg::sLoad) begin
      txData <= txByte;
      txValid <= 1'b1;
    end else if (state_q == rsq_pkg::sSend && txReady) begin
      txValid <= 1'b0;
      txIdx_q <= txIdx_q + 9'h001;
      appRdIdx <= 8'(txIdx_q - 9'h002);
    end
  end

  rsq_crc16 u_crc (
    .clock(clock),
    .rst(rst),
    .clear(crcClr),
    .update(crcUpd),
    .data(crcIn),
    .crc(crcVal)
  );

  rsq_frame_mem u_mem (
    .clock(clock),
    .rst(rst),
    .wrEn(memWr),
    .wrAddr(rxLen_q[7:0]),
    .wrData(rxIn.data),
    .rdAddr(memRdAddr),
    .rdData(memRd)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_read_first;
    txValid && txReady && kind_q == rsq_pkg::kRead && txIdx_q == 9'h000;
  endsequence
  sequence seq_next_byte_func;
    ##3 (txValid && txData == func);
  endsequence

  property p_own_only;
    state_q == rsq_pkg::sWait |-> addr == station && station <= `RSQ_STN_MAX;
  endproperty
  a_own_only: assert property (p_own_only) else $error("reply to foreign address");
  property p_no_bcast_reply;
    txValid |-> addr != `RSQ_ADDR_BCAST;
  endproperty
  a_no_bcast_reply: assert property (p_no_bcast_reply) else $error("broadcast answered");
  property p_group_quiet;
    txValid |-> !bcast_q && addr < `RSQ_GRP_A0;
  endproperty
  a_group_quiet: assert property (p_group_quiet) else $error("group write answered");
  property p_read_hdr;
    seq_read_first |-> txData == addr ##0 seq_next_byte_func;
  endproperty
  a_read_hdr: assert property (p_read_hdr) else $error("read reply header wrong");
  property p_loop;
    state_q == rsq_pkg::sCheck && state_d == rsq_pkg::sWait && func == `RSQ_FN_LOOPBACK
      |=> kind_q == rsq_pkg::kEcho && bodyLen_q == rxLen_q - 9'h002;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not echoed");
  property p_crc_lo;
    txValid && txIdx_q == bodyLen_q |-> txData == crcVal[7:0];
  endproperty
  a_crc_lo: assert property (p_crc_lo) else $error("crc low byte wrong");
  property p_gap;
    state_q == rsq_pkg::sWait && rxIn.valid |=> state_q == rsq_pkg::sIdle [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("reply despite short gap");
  property p_wait;
    state_q == rsq_pkg::sFetch && $past(state_q) == rsq_pkg::sWait
      |-> $past(msCnt_q) == waitMs && $past(idle_q) >= t35;
  endproperty
  a_wait: assert property (p_wait) else $error("reply started early");
  property p_exc_func;
    txValid && kind_q == rsq_pkg::kExc && txIdx_q == 9'h001
      |-> txData == (func | `RSQ_EXC_FLAG) && bodyLen_q == 9'h003;
  endproperty
  a_exc_func: assert property (p_exc_func) else $error("exception function wrong");
  property p_unsup;
    state_q == rsq_pkg::sCheck && accept && own && !known
      |=> kind_q == rsq_pkg::kExc && excCode_q == `RSQ_EXC_NO_FUNC;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported code not 01h");
  property p_bad_drop;
    state_q == rsq_pkg::sCheck && (rxBad_q || crcVal != 16'h0000) |=> state_q == rsq_pkg::sIdle;
  endproperty
  a_bad_drop: assert property (p_bad_drop) else $error("bad frame not dropped");
  property p_len_drop;
    state_q == rsq_pkg::sCheck && !lenOk |=> state_q == rsq_pkg::sIdle;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("bad length not dropped");
  property p_exc_noexec;
    state_q == rsq_pkg::sAsk && appAck && appExc != 8'h00 |=> !appWrValid [*3];
  endproperty
  a_exc_noexec: assert property (p_exc_noexec) else $error("write after exception");
endmodule : rsq_query_slave
`default_nettype wire

// file: testbench/rsq_master_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.svh"
module rsq_master_model (
  input wire logic clock,
  input wire logic [15:0] bitCycles,
  output var rsq_pkg::rsq_rx_t rxIn,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  logic [7:0] got[$];
  int cyc = 0;
  int lastRxCyc = 0;
  int lastTxCyc = 0;
  int firstTxCyc = 0;
  bit slow = 1'b0;
  initial begin
    rxIn = '{valid: 1'b0, err: 1'b0, data: 8'h00};
    txReady = 1'b0;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (txValid === 1'b1 && firstTxCyc == 0) firstTxCyc = cyc;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txData);
      lastTxCyc = cyc;
    end
    #1;
    // Stalls in slow mode so the held reply byte is exercised
    txReady = !slow || cyc[1];
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `RSQ_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ `RSQ_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [7:0] q[$], input bit badCrc, input bit badChar);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, badCrc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    // Idle margin above the minimum, since bit timing here is coarse
    while (cyc - lastTxCyc < 30 * bitCycles) @(posedge clock);
    foreach (q[i]) begin
      @(posedge clock);
      #1;
      rxIn = '{valid: 1'b1, err: badChar && i == 1, data: q[i]};
      @(posedge clock);
      #1;
      rxIn.valid = 1'b0;
      rxIn.data = ~q[i];
      lastRxCyc = cyc;
      repeat (2) @(posedge clock);
    end
  endtask : send
endmodule : rsq_master_model
`default_nettype wire

// file: testbench/rsq_query_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.svh"
module rsq_query_slave_tb;
  localparam int TMIN = 24 * 2 + 2 * 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  rsq_pkg::rsq_rx_t rxIn;
  logic [7:0] station = 8'h05;
  logic [15:0] bitCycles = 16'h0002;
  logic [10:0] replyExtraWaitTime = 11'h002;
  logic [7:0] txData, appRdIdx, appRdByte, appWrIdx, appWrByte;
  logic txValid, txReady, appReqValid, appBcast, appWrValid, lastBcast;
  rsq_pkg::rsq_req_t appReq, lastReq;
  logic appAck = 1'b0;
  logic [7:0] appExc = 8'h00;
  logic [7:0] appCode = 8'h00;
  logic [7:0] wr[$] = {8'h06, 8'h00, 8'h01, 8'h00, 8'h07};
  int miscompares = 0;
  int comparisons = 0;
  int reqCount = 0;
  int wrCount = 0;
  logic [15:0] wrGot[$];
  always #10 clock = ~clock;
  assign appRdByte = appRdIdx + 8'hA0;
  rsq_query_slave #(.CYC_PER_MS(4)) dut (.clock(clock), .rst(rst), .rxIn(rxIn),
    .station(station), .bitCycles(bitCycles), .replyExtraWaitTime(replyExtraWaitTime),
    .txData(txData), .txValid(txValid), .txReady(txReady), .appReq(appReq),
    .appReqValid(appReqValid), .appBcast(appBcast), .appAck(appAck), .appExc(appExc),
    .appRdIdx(appRdIdx), .appRdByte(appRdByte), .appWrValid(appWrValid),
    .appWrIdx(appWrIdx), .appWrByte(appWrByte));
  rsq_master_model master (.clock(clock), .bitCycles(bitCycles), .rxIn(rxIn),
    .txData(txData), .txValid(txValid), .txReady(txReady));
  always @(posedge clock) begin
    #1;
    if (appWrValid === 1'b1) begin
      wrCount++;
      wrGot.push_back({appWrIdx, appWrByte});
    end
    if (appAck === 1'b1) appAck = 1'b0;
    else if (appReqValid === 1'b1) begin
      appAck = 1'b1;
      appExc = appCode;
      lastReq = appReq;
      lastBcast = appBcast;
      reqCount++;
    end
    if (master.cyc == 30000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic query(input logic [7:0] q[$], input bit badCrc, input bit badChar);
    master.got.delete();
    master.firstTxCyc = 0;
    master.send(q, badCrc, badChar);
  endtask : query
  task automatic reply(input logic [7:0] q[$]);
    logic [15:0] c;
    c = master.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    for (int i = 0; i < 3000 && master.got.size() < q.size(); i++) @(posedge clock);
    check(master.got.size(), q.size(), "reply length");
    foreach (q[i]) if (i < master.got.size()) check(master.got[i], q[i], "reply byte");
    check(master.firstTxCyc - master.lastRxCyc >= TMIN, 1, "reply delay");
  endtask : reply
  task automatic silent(input logic [7:0] q[$], input bit badCrc, input bit badChar, input int n);
    int r0;
    r0 = reqCount;
    query(q, badCrc, badChar);
    repeat (200) @(posedge clock);
    check(master.firstTxCyc, 0, "no reply");
    check(reqCount - r0, n, "request count");
  endtask : silent
  task automatic t_write;
    logic [15:0] wexp[$];
    logic [7:0] mw[$];
    wexp = {16'h0200, 16'h0312, 16'h0412, 16'h0534};
    mw = {8'h05, `RSQ_FN_WR_REGS, 8'h00, 8'h01, 8'h00, 8'h02,
          8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
    wrCount = 0;
    wrGot.delete();
    query({8'h05, `RSQ_FN_WR_REG, 8'h00, 8'h12, 8'h12, 8'h34}, 0, 0);
    reply({8'h05, 8'h06, 8'h00, 8'h12, 8'h12, 8'h34});
    check(lastBcast, 1'b0, "own flag");
    check({8'h00, lastReq.func}, 16'h0006, "function");
    check(lastReq.start, 16'h0012, "start");
    check(lastReq.qty, 16'h1234, "value");
    check(wrCount, 4, "write bytes");
    foreach (wexp[i]) check(wrGot[i], wexp[i], "write byte");
    wrCount = 0;
    query(mw, 0, 0);
    reply(mw);
    check(wrCount, 9, "multi write bytes");
    query({8'h05, `RSQ_FN_WR_COIL, 8'h00, 8'h03, 8'hFF, 8'h00}, 0, 0);
    reply({8'h05, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00});
    $display("test write done");
  endtask : t_write
  task automatic t_read;
    master.slow = 1'b1;
    query({8'h05, `RSQ_FN_RD_REGS, 8'h00, 8'h00, 8'h00, 8'h02}, 0, 0);
    reply({8'h05, 8'h03, 8'h04, 8'hA0, 8'hA1, 8'hA2, 8'hA3});
    query({8'h05, `RSQ_FN_RD_COILS, 8'h00, 8'h06, 8'h00, 8'h05}, 0, 0);
    reply({8'h05, 8'h01, 8'h01, 8'hA0});
    master.slow = 1'b0;
    query({8'h05, `RSQ_FN_LOOPBACK, 8'h00, 8'h00, 8'h5A, 8'hA5, 8'h3C}, 0, 0);
    reply({8'h05, 8'h08, 8'h00, 8'h00, 8'h5A, 8'hA5, 8'h3C});
    $display("test read and loopback done");
  endtask : t_read
  task automatic t_exc;
    logic [7:0] fn[$];
    logic [7:0] code[$];
    fn = {8'h41, 8'h17};
    code = {8'h02, 8'h21, 8'h22, 8'h23};
    foreach (fn[i]) begin
      query({8'h05, fn[i], 8'h00, 8'h00, 8'h00, 8'h01}, 0, 0);
      reply({8'h05, fn[i] + 8'h80, 8'h01});
    end
    query({8'h05, `RSQ_FN_RD_REGS, 8'h00, 8'h00, 8'h00, 8'h11}, 0, 0);
    reply({8'h05, 8'h83, 8'h03});
    query({8'h05, `RSQ_FN_RD_COILS, 8'h00, 8'h00, 8'h00, 8'h21}, 0, 0);
    reply({8'h05, 8'h81, 8'h03});
    query({8'h05, `RSQ_FN_WR_COIL, 8'h00, 8'h03, 8'h12, 8'h34}, 0, 0);
    reply({8'h05, 8'h85, 8'h03});
    query({8'h05, `RSQ_FN_WR_COILS, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h01, 8'hFF}, 0, 0);
    reply({8'h05, 8'h8F, 8'h03});
    foreach (code[i]) begin
      appCode = code[i];
      wrCount = 0;
      query({8'h05, wr}, 0, 0);
      reply({8'h05, 8'h86, code[i]});
      check(wrCount, 0, "write after exception");
    end
    appCode = 8'h00;
    $display("test exceptions done");
  endtask : t_exc
  task automatic t_silent;
    silent({8'h06, wr}, 0, 0, 0);
    silent({8'h00, wr}, 0, 0, 1);
    check(lastBcast, 1'b1, "broadcast flag");
    silent({8'h00, 8'h08, 8'h00, 8'h00}, 0, 0, 0);
    silent({8'hFA, wr}, 0, 0, 1);
    check(lastBcast, 1'b1, "group flag");
    silent({8'hFB, wr}, 0, 0, 0);
    silent({8'hFA, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0, 0, 0);
    silent({8'h05, wr}, 1, 0, 0);
    silent({8'h05, wr}, 0, 1, 0);
    silent({8'h05, wr, 8'h00}, 0, 0, 0);
    $display("test silent cases done");
  endtask : t_silent
  task automatic t_gap;
    #1 replyExtraWaitTime = 11'h00A;
    query({8'h05, wr}, 0, 0);
    repeat (60) @(posedge clock);
    master.send({8'h05}, 0, 0);
    repeat (300) @(posedge clock);
    check(master.firstTxCyc, 0, "reply after short gap");
    #1 replyExtraWaitTime = 11'h002;
    // Master times out and resends the same query
    query({8'h05, wr}, 0, 0);
    reply({8'h05, wr});
    $display("test short gap done");
  endtask : t_gap
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    check(txValid, 1'b0, "idle after reset");
    t_write;
    t_read;
    t_exc;
    t_silent;
    t_gap;
    test_done();
  end
endmodule : rsq_query_slave_tb
`default_nettype wire
